// [logic/prt_pkg.sv]
// shared constants for the protection trip aggregator
package prt_pkg;

  // clock and time base
  localparam int CLK_HZ       = 25_000_000;  // ref_clk rate
  localparam int MS_PER_S     = 1000;
  localparam int MS_CLKS      = CLK_HZ / MS_PER_S;  // clocks per millisecond
  localparam int CYCLE_CLKS   = 2500;        // clocks per program cycle

  // register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_FUNC_EN    = 8'h04;
  localparam logic [7:0] OFS_EV_ON_SEL  = 8'h08;
  localparam logic [7:0] OFS_EV_OFF_SEL = 8'h0c;
  localparam logic [7:0] OFS_COND       = 8'h10;
  localparam logic [7:0] OFS_CNT_CLR    = 8'h14;
  localparam logic [7:0] OFS_ARC_CNT    = 8'h18;
  localparam logic [7:0] OFS_START_CNT  = 8'h1c;
  localparam logic [7:0] OFS_TRIP_CNT   = 8'h20;
  localparam logic [7:0] OFS_IRQ_STAT   = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h28;
  localparam logic [7:0] OFS_TIME_MS    = 8'h2c;
  localparam logic [7:0] OFS_HIST_SEL   = 8'h30;
  localparam logic [7:0] OFS_HIST_STAMP = 8'h34;
  localparam logic [7:0] OFS_HIST_INFO  = 8'h38;
  localparam logic [7:0] OFS_HIST_IAB   = 8'h3c;
  localparam logic [7:0] OFS_HIST_ICR   = 8'h40;

  // control register fields
  localparam int CTRL_FORCE_ALLOW = 0;
  localparam int CTRL_FORCE_LO    = 1;  // two-bit force select at [2:1]
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // counter clear command bits
  localparam int CLR_ARC   = 0;
  localparam int CLR_START = 1;
  localparam int CLR_TRIP  = 2;

  // interrupt status bits
  localparam int IRQ_W         = 5;
  localparam int IRQ_COM_START = 0;
  localparam int IRQ_COM_TRIP  = 1;
  localparam int IRQ_ARC_TRIP  = 2;
  localparam int IRQ_ARC_BLK   = 3;
  localparam int IRQ_EV_OVF    = 4;

  // arc stage and event layout
  localparam int NUM_ZONES      = 4;
  localparam int ARC_STATUS_W   = 18;
  localparam int EV_ZONE_TRIP   = 0;
  localparam int EV_ZONE_BLK    = 4;
  localparam int NUM_ARC_EVENTS = 26;
  localparam int EV_COM_START   = 26;
  localparam int EV_COM_TRIP    = 27;
  localparam int NUM_EVENTS     = 28;
  localparam int EV_IDX_W       = 5;

  // history
  localparam int HIST_DEPTH = 12;
  localparam int HIST_IDX_W = 4;
  localparam int CUR_W      = 16;
  localparam int SENS_W     = 4;
  localparam int GRP_W      = 3;

  typedef enum logic [1:0] {PRT_FORCE_NORMAL, PRT_FORCE_START, PRT_FORCE_TRIP} prt_force_e;
  typedef enum logic [1:0] {PRT_COND_NORMAL, PRT_COND_START, PRT_COND_TRIP} prt_cond_e;
  typedef enum logic [1:0] {PRT_ZONE_IDLE, PRT_ZONE_TRIP, PRT_ZONE_BLOCKED} prt_zone_e;

endpackage : prt_pkg

// [logic/prt_trip_aggregator.sv]
// protection trip aggregator: arc zone gating, common signals, events, history
`timescale 1ns/1ps
`default_nettype none

module prt_trip_aggregator
  import prt_pkg::*;
#(
  parameter int NUM_FUNCS  = 16,
  parameter int NUM_EXTRA  = 4,
  parameter int MS_DIV     = MS_CLKS,
  parameter int CYCLE_DIV  = CYCLE_CLKS
) (
  input  wire logic                    ref_clk,
  input  wire logic                    resetn,
  // register port
  input  wire logic [ADDR_W-1:0]       reg_addr,
  input  wire logic [DATA_W-1:0]       reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [DATA_W-1:0]       reg_rdata,
  // arc stage
  input  wire logic [NUM_ZONES-1:0]    zone_pickup,
  input  wire logic [NUM_ZONES-1:0]    zone_block_in,
  input  wire logic [ARC_STATUS_W-1:0] arc_status,
  input  wire logic [CUR_W-1:0]        cur_a,
  input  wire logic [CUR_W-1:0]        cur_b,
  input  wire logic [CUR_W-1:0]        cur_c,
  input  wire logic [CUR_W-1:0]        cur_res,
  input  wire logic [SENS_W-1:0]       sensor_active,
  input  wire logic [GRP_W-1:0]        setting_group,
  output logic      [NUM_ZONES-1:0]    zone_trip,
  output logic      [NUM_ZONES-1:0]    zone_blocked,
  // common signals
  input  wire logic [NUM_FUNCS-1:0]    func_start,
  input  wire logic [NUM_FUNCS-1:0]    func_trip,
  input  wire logic [NUM_EXTRA-1:0]    extra_start,
  input  wire logic [NUM_EXTRA-1:0]    extra_trip,
  output logic                         common_start,
  output logic                         common_trip,
  // event stream to the main event buffer
  output logic                         ev_valid,
  output logic      [EV_IDX_W-1:0]     ev_code,
  output logic                         ev_on,
  output logic      [DATA_W-1:0]       ev_stamp,
  output logic                         irq
);

  // assertion defaults, declared ahead of every property that leans on them
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////////
  // time base

  logic [$clog2(MS_DIV)-1:0]    ms_div;
  logic [$clog2(CYCLE_DIV)-1:0] cyc_div;
  logic                         ms_tick;
  logic                         tick;
  logic                         tick_d;
  logic [DATA_W-1:0]            time_ms;

  // millisecond enable
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ms_div  <= '0;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= (ms_div == ($clog2(MS_DIV))'(MS_DIV - 1));
      ms_div  <= (ms_div == ($clog2(MS_DIV))'(MS_DIV - 1)) ? '0 : ms_div + 1'b1;
    end
  end

  // program cycle enable, decision stage one clock later
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cyc_div <= '0;
      tick    <= 1'b0;
      tick_d  <= 1'b0;
    end else begin
      tick    <= (cyc_div == ($clog2(CYCLE_DIV))'(CYCLE_DIV - 1));
      cyc_div <= (cyc_div == ($clog2(CYCLE_DIV))'(CYCLE_DIV - 1)) ? '0 : cyc_div + 1'b1;
      tick_d  <= tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers written by software

  logic [DATA_W-1:0]          ctrl;
  logic [NUM_FUNCS-1:0]       func_en;
  logic [NUM_EVENTS-1:0]      ev_on_sel;
  logic [NUM_EVENTS-1:0]      ev_off_sel;
  logic [IRQ_W-1:0]           irq_mask;
  logic [HIST_IDX_W-1:0]      hist_sel;
  logic                       wr_time;
  logic [2:0]                 cnt_clr;
  prt_force_e                 force_sel;
  logic                       force_allow;

  assign force_allow = ctrl[CTRL_FORCE_ALLOW];
  assign force_sel   = prt_force_e'(ctrl[CTRL_FORCE_LO +: 2]);
  assign wr_time     = reg_wr && (reg_addr == OFS_TIME_MS);
  assign cnt_clr     = (reg_wr && (reg_addr == OFS_CNT_CLR)) ? reg_wdata[2:0] : 3'h0;

  // static settings, not tied to setting_group
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl       <= CTRL_RESET;  // force select defaults to normal
      func_en    <= '1;
      ev_on_sel  <= '1;
      ev_off_sel <= '1;
      irq_mask   <= '0;
      hist_sel   <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_CTRL:       ctrl       <= reg_wdata;
        OFS_FUNC_EN:    func_en    <= reg_wdata[NUM_FUNCS-1:0];
        OFS_EV_ON_SEL:  ev_on_sel  <= reg_wdata[NUM_EVENTS-1:0];
        OFS_EV_OFF_SEL: ev_off_sel <= reg_wdata[NUM_EVENTS-1:0];
        OFS_IRQ_MASK:   irq_mask   <= reg_wdata[IRQ_W-1:0];
        OFS_HIST_SEL:   hist_sel   <= (reg_wdata[HIST_IDX_W-1:0] < HIST_IDX_W'(HIST_DEPTH)) ?
                                      reg_wdata[HIST_IDX_W-1:0] : hist_sel;
        default:        ;
      endcase
    end
  end

  // running millisecond clock, software sets it
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      time_ms <= '0;
    end else if (wr_time) begin
      time_ms <= reg_wdata;
    end else if (ms_tick) begin
      time_ms <= time_ms + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // arc zone gating

  logic [NUM_ZONES-1:0] blk_s;
  logic [NUM_ZONES-1:0] pick_s;
  prt_zone_e            zone_state [NUM_ZONES];

  // one sample of block and pick-up per program cycle; the blocker's own
  // timing must lead the operate delay
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      blk_s  <= '0;
      pick_s <= '0;
    end else if (tick) begin
      blk_s  <= zone_block_in;
      pick_s <= zone_pickup;
    end
  end

  for (genvar g = 0; g < NUM_ZONES; g++) begin : g_zone
    // pick-up decides trip or blocked, then holds until pick-up drops
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        zone_state[g] <= PRT_ZONE_IDLE;
      end else if (tick_d) begin
        case (zone_state[g])
          PRT_ZONE_IDLE: begin
            if (pick_s[g]) begin
              zone_state[g] <= blk_s[g] ? PRT_ZONE_BLOCKED : PRT_ZONE_TRIP;
            end
          end
          PRT_ZONE_TRIP, PRT_ZONE_BLOCKED: begin
            if (!pick_s[g]) begin
              zone_state[g] <= PRT_ZONE_IDLE;  // blocked pick-up never trips
            end
          end
          default: zone_state[g] <= PRT_ZONE_IDLE;
        endcase
      end
    end

    // zone outputs from state
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        zone_trip[g]    <= 1'b0;
        zone_blocked[g] <= 1'b0;
      end else begin
        zone_trip[g]    <= (zone_state[g] == PRT_ZONE_TRIP);
        zone_blocked[g] <= (zone_state[g] == PRT_ZONE_BLOCKED);
      end
    end

    a_zone_trips: assert property (tick_d && zone_state[g] == PRT_ZONE_IDLE && pick_s[g]
      && !blk_s[g] |=> zone_state[g] == PRT_ZONE_TRIP ##1 zone_trip[g])
      else $error("zone did not trip on unblocked pick-up");
    a_zone_blocks: assert property (tick_d && zone_state[g] == PRT_ZONE_IDLE && pick_s[g]
      && blk_s[g] |=> zone_state[g] == PRT_ZONE_BLOCKED ##1 (zone_blocked[g] && !zone_trip[g]))
      else $error("zone did not block on blocked pick-up");
    a_blocked_stays: assert property (zone_state[g] == PRT_ZONE_BLOCKED
      |=> zone_state[g] != PRT_ZONE_TRIP)
      else $error("blocked zone went to trip");
  end

  ////////////////////////////////////////////////////////////////////////////
  // common signals, no blocking input of their own

  logic raw_start;
  logic raw_trip;

  assign raw_start = |(func_start & func_en) | (|extra_start);
  assign raw_trip  = |(func_trip & func_en) | (|extra_trip);

  // forcing overrides only while allowed; forced trip also shows start
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      common_start <= 1'b0;
      common_trip  <= 1'b0;
    end else if (force_allow && force_sel == PRT_FORCE_START) begin
      common_start <= 1'b1;
      common_trip  <= 1'b0;
    end else if (force_allow && force_sel == PRT_FORCE_TRIP) begin
      common_start <= 1'b1;
      common_trip  <= 1'b1;
    end else begin
      common_start <= raw_start;
      common_trip  <= raw_trip;
    end
  end

  prt_cond_e cond;

  // condition seen by software
  always_comb begin
    if (common_trip) begin
      cond = PRT_COND_TRIP;
    end else if (common_start) begin
      cond = PRT_COND_START;
    end else begin
      cond = PRT_COND_NORMAL;
    end
  end

  a_common_or: assert property (!force_allow && raw_start |=> common_start)
    else $error("common start missed an enabled start");
  a_force_trip: assert property (force_allow && force_sel == PRT_FORCE_TRIP
    |=> common_trip && common_start)
    else $error("forced trip not shown on common outputs");
  a_force_gated: assert property (!force_allow && !raw_trip |=> !common_trip)
    else $error("common trip without cause while forcing disallowed");
  a_cond_trip: assert property (common_trip |-> cond == PRT_COND_TRIP)
    else $error("condition does not show trip");

  ////////////////////////////////////////////////////////////////////////////
  // event detection and stream

  logic [NUM_EVENTS-1:0] ev_now;
  logic [NUM_EVENTS-1:0] ev_prev;
  logic [NUM_EVENTS-1:0] rise;
  logic [NUM_EVENTS-1:0] fall;
  logic [NUM_EVENTS-1:0] pend_on;
  logic [NUM_EVENTS-1:0] pend_off;
  logic [NUM_EVENTS-1:0] next_pend_on;
  logic [NUM_EVENTS-1:0] next_pend_off;
  logic [DATA_W-1:0]     batch_stamp;
  logic                  pick_found;
  logic                  pick_on;
  logic [EV_IDX_W-1:0]   pick_idx;
  logic                  ev_ovf;

  // all arc and common status bits in one vector
  assign ev_now = {common_trip, common_start, arc_status, zone_blocked, zone_trip};
  assign rise   = ev_now & ~ev_prev;
  assign fall   = ~ev_now & ev_prev;
  assign ev_ovf = tick && (|((pend_on | pend_off) & ((rise & ev_on_sel) | (fall & ev_off_sel))));

  // previous status, one edge per program cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ev_prev <= '0;
    end else if (tick) begin
      ev_prev <= ev_now;
    end
  end

  // lowest pending event first, ON before OFF
  always_comb begin
    pick_found = 1'b0;
    pick_on    = 1'b0;
    pick_idx   = '0;
    for (int i = NUM_EVENTS - 1; i >= 0; i--) begin
      if (pend_on[i] || pend_off[i]) begin
        pick_found = 1'b1;
        pick_on    = pend_on[i];
        pick_idx   = EV_IDX_W'(i);
      end
    end
  end

  // drain clears, a new edge in the same clock wins
  always_comb begin
    next_pend_on  = pend_on;
    next_pend_off = pend_off;
    if (pick_found && pick_on) begin
      next_pend_on[pick_idx] = 1'b0;
    end else if (pick_found) begin
      next_pend_off[pick_idx] = 1'b0;
    end
    if (tick) begin
      next_pend_on  = next_pend_on | (rise & ev_on_sel);
      next_pend_off = next_pend_off | (fall & ev_off_sel);
    end
  end

  // pending sets and the stamp of the cycle that raised them
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pend_on     <= '0;
      pend_off    <= '0;
      batch_stamp <= '0;
    end else begin
      pend_on  <= next_pend_on;
      pend_off <= next_pend_off;
      if (tick && (|(rise | fall))) begin
        batch_stamp <= time_ms;
      end
    end
  end

  // event stream outputs
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ev_valid <= 1'b0;
      ev_code  <= '0;
      ev_on    <= 1'b0;
      ev_stamp <= '0;
    end else begin
      ev_valid <= pick_found;
      ev_code  <= pick_idx;
      ev_on    <= pick_on;
      ev_stamp <= batch_stamp;
    end
  end

  a_prev_tracks: assert property (tick |=> ev_prev == $past(ev_now))
    else $error("status history not updated on cycle tick");
  a_on_selected: assert property (tick && rise[EV_COM_TRIP] && ev_on_sel[EV_COM_TRIP]
    |=> pend_on[EV_COM_TRIP])
    else $error("selected common trip ON event not queued");

  ////////////////////////////////////////////////////////////////////////////
  // cumulative counters

  logic [DATA_W-1:0] arc_cnt;
  logic [DATA_W-1:0] start_cnt;
  logic [DATA_W-1:0] trip_cnt;
  logic [EV_IDX_W-1:0] arc_inc;

  // number of arc status edges this cycle
  always_comb begin
    arc_inc = '0;
    for (int i = 0; i < NUM_ARC_EVENTS; i++) begin
      arc_inc = arc_inc + EV_IDX_W'(rise[i] | fall[i]);
    end
  end

  // clear and count in the same clock keeps the count
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      arc_cnt   <= '0;
      start_cnt <= '0;
      trip_cnt  <= '0;
    end else begin
      arc_cnt   <= (cnt_clr[CLR_ARC] ? '0 : arc_cnt)
                   + (tick ? DATA_W'(arc_inc) : '0);
      start_cnt <= (cnt_clr[CLR_START] ? '0 : start_cnt)
                   + DATA_W'(tick & rise[EV_COM_START]);
      trip_cnt  <= (cnt_clr[CLR_TRIP] ? '0 : trip_cnt)
                   + DATA_W'(tick & rise[EV_COM_TRIP]);
    end
  end

  a_trip_count: assert property (tick && rise[EV_COM_TRIP] && !cnt_clr[CLR_TRIP]
    |=> trip_cnt == $past(trip_cnt) + 1)
    else $error("trip counter did not step");
  a_arc_clear: assert property (cnt_clr[CLR_ARC] && !tick |=> arc_cnt == '0)
    else $error("arc counter not cleared");

  ////////////////////////////////////////////////////////////////////////////
  // operation history

  logic [HIST_IDX_W-1:0] wr_ptr;
  logic [HIST_IDX_W-1:0] hist_cnt;
  logic [HIST_IDX_W-1:0] rd_idx;
  logic [HIST_IDX_W:0]   rd_sum;
  logic                  hist_we;
  logic [EV_IDX_W-1:0]   rec_code;
  logic [DATA_W-1:0]     h_stamp [HIST_DEPTH];
  logic [EV_IDX_W-1:0]   h_code  [HIST_DEPTH];
  logic [CUR_W-1:0]      h_ia    [HIST_DEPTH];
  logic [CUR_W-1:0]      h_ib    [HIST_DEPTH];
  logic [CUR_W-1:0]      h_ic    [HIST_DEPTH];
  logic [CUR_W-1:0]      h_ir    [HIST_DEPTH];
  logic [SENS_W-1:0]     h_sens  [HIST_DEPTH];
  logic [GRP_W-1:0]      h_grp   [HIST_DEPTH];

  assign hist_we = tick && (|rise[EV_ZONE_TRIP +: NUM_ZONES]);
  // selected age, 0 is the newest record
  assign rd_sum  = {1'b0, wr_ptr} + (HIST_IDX_W+1)'(HIST_DEPTH - 1) - {1'b0, hist_sel};
  assign rd_idx  = (rd_sum >= (HIST_IDX_W+1)'(HIST_DEPTH)) ?
                   HIST_IDX_W'(rd_sum - (HIST_IDX_W+1)'(HIST_DEPTH)) : rd_sum[HIST_IDX_W-1:0];

  // lowest tripping zone names the record
  always_comb begin
    rec_code = '0;
    for (int i = NUM_ZONES - 1; i >= 0; i--) begin
      if (rise[EV_ZONE_TRIP + i]) begin
        rec_code = EV_IDX_W'(EV_ZONE_TRIP + i);
      end
    end
  end

  // circular pointer, oldest record overwritten
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr   <= '0;
      hist_cnt <= '0;
    end else if (hist_we) begin
      wr_ptr   <= (wr_ptr == HIST_IDX_W'(HIST_DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      hist_cnt <= (hist_cnt == HIST_IDX_W'(HIST_DEPTH)) ? hist_cnt : hist_cnt + 1'b1;
    end
  end

  // record store
  always_ff @(posedge ref_clk) begin
    if (hist_we) begin
      h_stamp[wr_ptr] <= time_ms;
      h_code[wr_ptr]  <= rec_code;
      h_ia[wr_ptr]    <= cur_a;
      h_ib[wr_ptr]    <= cur_b;
      h_ic[wr_ptr]    <= cur_c;
      h_ir[wr_ptr]    <= cur_res;
      h_sens[wr_ptr]  <= sensor_active;
      h_grp[wr_ptr]   <= setting_group;
    end
  end

  a_hist_wrap: assert property (hist_we && wr_ptr == HIST_IDX_W'(HIST_DEPTH - 1)
    |=> wr_ptr == '0)
    else $error("history pointer did not wrap after twelve records");

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status, read clears, a set in the same clock wins

  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_set;
  logic             rd_stat;

  assign rd_stat = reg_rd && (reg_addr == OFS_IRQ_STAT);
  always_comb begin
    irq_set                = '0;
    irq_set[IRQ_COM_START] = tick & rise[EV_COM_START];
    irq_set[IRQ_COM_TRIP]  = tick & rise[EV_COM_TRIP];
    irq_set[IRQ_ARC_TRIP]  = tick & (|rise[EV_ZONE_TRIP +: NUM_ZONES]);
    irq_set[IRQ_ARC_BLK]   = tick & (|rise[EV_ZONE_BLK +: NUM_ZONES]);
    irq_set[IRQ_EV_OVF]    = ev_ovf;
  end

  // sticky bits and level output
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat <= '0;
      irq      <= 1'b0;
    end else begin
      irq_stat <= (rd_stat ? '0 : irq_stat) | irq_set;
      irq      <= |(((rd_stat ? '0 : irq_stat) | irq_set) & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port, data in the clock after the strobe

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL:       reg_rdata <= ctrl;
        OFS_FUNC_EN:    reg_rdata <= DATA_W'(func_en);
        OFS_EV_ON_SEL:  reg_rdata <= DATA_W'(ev_on_sel);
        OFS_EV_OFF_SEL: reg_rdata <= DATA_W'(ev_off_sel);
        OFS_COND:       reg_rdata <= DATA_W'({zone_blocked, zone_trip, cond});
        OFS_ARC_CNT:    reg_rdata <= arc_cnt;
        OFS_START_CNT:  reg_rdata <= start_cnt;
        OFS_TRIP_CNT:   reg_rdata <= trip_cnt;
        OFS_IRQ_STAT:   reg_rdata <= DATA_W'(irq_stat);
        OFS_IRQ_MASK:   reg_rdata <= DATA_W'(irq_mask);
        OFS_TIME_MS:    reg_rdata <= time_ms;
        OFS_HIST_SEL:   reg_rdata <= DATA_W'({hist_cnt, hist_sel});
        OFS_HIST_STAMP: reg_rdata <= h_stamp[rd_idx];
        OFS_HIST_INFO:  reg_rdata <= DATA_W'({h_grp[rd_idx], h_sens[rd_idx], h_code[rd_idx]});
        OFS_HIST_IAB:   reg_rdata <= {h_ib[rd_idx], h_ia[rd_idx]};
        OFS_HIST_ICR:   reg_rdata <= {h_ir[rd_idx], h_ic[rd_idx]};
        default:        reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule : prt_trip_aggregator

`default_nettype wire

// [test/prt_blk_model.sv]
// blocking matrix model driving the zone block inputs
`timescale 1ns/1ps
`default_nettype none
module prt_blk_model
  import prt_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic [NUM_ZONES-1:0] want_block,
  output logic      [NUM_ZONES-1:0] zone_block_in
);
  // block follows want_block one ref_clk later; the bench raises it ahead of pick-up
  always_ff @(posedge ref_clk) begin
    zone_block_in <= want_block;
  end
endmodule : prt_blk_model
`default_nettype wire

// [test/protection_trip_aggregator_tb.sv]
// self-checking bench for the trip aggregator
`timescale 1ns/1ps
`default_nettype none
module protection_trip_aggregator_tb;
  import prt_pkg::*;
  logic        ref_clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0;
  logic        ev_valid, ev_on, irq, cs, ct;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, stamp, v;
  logic [3:0]  pick = 4'h0, want = 4'h0, blk, ztrip, zblk, xs = 4'h0, xt = 4'h0;
  logic [15:0] fs = 16'h0, ft = 16'h0, cur = 16'h0123;
  logic [4:0]  code;
  logic [17:0] arc = 18'h00000;
  int          n_fail = 0;
  int          n_tests = 0;
  // clock
  always #20 ref_clk = ~ref_clk;
  prt_blk_model blkm (.ref_clk(ref_clk), .want_block(want), .zone_block_in(blk));
  prt_trip_aggregator #(.MS_DIV(10), .CYCLE_DIV(64)) dut (
    .ref_clk(ref_clk), .resetn(resetn), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .zone_pickup(pick),
    .zone_block_in(blk), .arc_status(arc), .cur_a(cur), .cur_b(cur),
    .cur_c(cur), .cur_res(cur), .sensor_active(4'h1), .setting_group(3'h2),
    .zone_trip(ztrip), .zone_blocked(zblk), .func_start(fs), .func_trip(ft),
    .extra_start(xs), .extra_trip(xt), .common_start(cs), .common_trip(ct),
    .ev_valid(ev_valid), .ev_code(code), .ev_on(ev_on), .ev_stamp(stamp), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task automatic tmo(input int i);
    if (i >= 300) begin
      n_fail++;
      summarize();
    end
  endtask : tmo
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr <= 1'b0;
    cyc(1);
  endtask : wreg
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
    cyc(1);
  endtask : rreg
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int i;
    int n;
    cyc(12);
    resetn <= 1'b1;
    cyc(1);
    rreg(OFS_CTRL, v);
    chk(v, CTRL_RESET);
    rreg(8'h44, v);
    chk(v, 32'h0);
    // common outputs, enables, extras and forcing
    fs <= 16'h0008;
    cyc(3);
    chk(cs, 1'b1);
    wreg(OFS_FUNC_EN, 32'h0);
    cyc(2);
    chk(cs, 1'b0);
    xt <= 4'h2;
    cyc(3);
    chk(ct, 1'b1);
    rreg(OFS_COND, v);
    chk(v, 32'h2);
    xt <= 4'h0;
    wreg(OFS_CTRL, 32'h4);
    cyc(2);
    chk(ct, 1'b0);
    wreg(OFS_CTRL, 32'h5);
    cyc(2);
    chk({cs, ct}, 2'b11);
    wreg(OFS_CTRL, 32'h3);
    cyc(2);
    chk({cs, ct}, 2'b10);
    wreg(OFS_CTRL, 32'h0);
    fs <= 16'h0;
    cyc(300);
    // zone trip, its event, counter, history and interrupt
    wreg(OFS_IRQ_MASK, 32'h4);
    wreg(OFS_CNT_CLR, 32'h1);
    chk(irq, 1'b0);
    wreg(OFS_TIME_MS, 32'h0000_1000);
    pick <= 4'h1;
    for (i = 0; i < 300 && ev_valid !== 1'b1; i++) cyc(1);
    tmo(i);
    chk({code, ev_on}, 6'h01);
    chk(stamp >= 32'h0000_1000 && stamp <= 32'h0000_1020, 1'b1);
    cyc(2);
    chk({ztrip, irq}, 5'h03);
    rreg(OFS_ARC_CNT, v);
    chk(v, 32'h1);
    rreg(OFS_HIST_SEL, v);
    chk(v, 32'h10);
    rreg(OFS_HIST_INFO, v);
    chk(v, 32'h0000_0420);
    rreg(OFS_HIST_IAB, v);
    chk(v, 32'h0123_0123);
    rreg(OFS_IRQ_STAT, v);
    chk({v[IRQ_ARC_TRIP], irq}, 2'b10);
    // pick-up under an active block
    want <= 4'h2;
    cyc(140);
    pick <= 4'h3;
    cyc(200);
    chk({zblk, ztrip}, 8'h21);
    // twelve more zone 2 trips wrap the history
    for (i = 0; i < 12; i++) begin
      pick <= 4'h7;
      cyc(150);
      pick <= 4'h3;
      cyc(150);
    end
    rreg(OFS_HIST_SEL, v);
    chk(v, 32'hc0);
    wreg(OFS_HIST_SEL, 32'hb);
    rreg(OFS_HIST_INFO, v);
    chk(v, 32'h0000_0422);
    // ON events deselected, OFF events and counters kept
    wreg(OFS_CNT_CLR, 32'h7);
    wreg(OFS_EV_ON_SEL, 32'h0);
    xt <= 4'h1;
    arc <= 18'h00001;
    n = 0;
    repeat (150) begin
      cyc(1);
      n += ev_valid;
    end
    chk(n, 0);
    xt <= 4'h0;
    arc <= 18'h00000;
    for (i = 0; i < 300 && ev_valid !== 1'b1; i++) cyc(1);
    tmo(i);
    chk({code, ev_on}, 6'h10);
    cyc(1);
    chk({code, ev_on}, 6'h36);
    rreg(OFS_ARC_CNT, v);
    chk(v, 32'h2);
    rreg(OFS_TRIP_CNT, v);
    chk(v, 32'h1);
    rreg(OFS_START_CNT, v);
    chk(v, 32'h0);
    summarize();
  end
endmodule : protection_trip_aggregator_tb
`default_nettype wire
